// ==== hdl/acs_ctrl.sv ====
// Contract
// (R01) single mode: conversion end sets end flag
// (R02) scan mode: flag set after whole group
// (R03) flag clears on write 0 after read 1
// (R04) end interrupt while flag and enable set
// (R05) writing start begins; reads 1 while converting
// (R06) single mode clears start when finished
// (R07) scan repeats until start cleared, reset, standby
// (R08) bit 4 selects single or scan mode
// (R09) bit 3 selects 134 or 70 states
// (R10) software clears start before changing speed
// (R11) single mode: field picks one input 0-3
// (R12) scan mode: field picks group from input 0
// (R13) results left-justified, low six bits zero
// (R14) each input has its own result register
// (R15) scan restarts at first channel automatically
// (R16) enabled trigger falling edge sets start bit
// (R17) channel values with top bit reserved
// (R18) reset clears register, stops, drops interrupt
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module acs_ctrl
   import acs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ACS_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic ext_conv_trigger,
   input wire logic standby_req,
   input wire logic [ACS_DATA_W-1:0] sar_data,
   output acs_sar_req_t sar_req,
   output logic conv_end_irq,
   output logic irq
);

   acs_ctrl_state_t s_q;
   acs_ctrl_state_t s_d;

   logic tmr_start;
   logic [ACS_CNT_W-1:0] tmr_len;
   logic tmr_abort;
   logic tmr_done;
   logic mem_we;
   logic [ACS_CH_W-1:0] mem_raddr;
   logic [ACS_RES_W-1:0] mem_rdata;
   logic [ACS_ADDR_W-1:0] res_off;
   logic is_csr;
   logic is_trig;
   logic is_res;
   logic is_stat;
   logic is_mask;
   logic addr_ok;
   logic xfer_done;
   logic [ACS_CSR_CHAN_W-1:0] chan_field;
   logic [ACS_CH_W-1:0] chan_last;
   logic scan_mode;
   logic fast;

   // ===========================================================
   // address decode
   // ===========================================================
   assign res_off = paddr - ACS_OFF_RES0;
   assign mem_raddr = res_off[ACS_WORD_LSB +: ACS_CH_W];
   assign is_csr = (paddr == ACS_OFF_CSR);
   assign is_trig = (paddr == ACS_OFF_TRIG);
   assign is_res = (paddr >= ACS_OFF_RES0) && (paddr <= ACS_OFF_RES3)
                   && (paddr[ACS_WORD_LSB-1:0] == ACS_WORD_ALIGN);
   assign is_stat = (paddr == ACS_OFF_IRQ_STAT);
   assign is_mask = (paddr == ACS_OFF_IRQ_MASK);
   // result words are read-only, so a write to them is refused too
   assign addr_ok = is_csr || is_trig || is_stat || is_mask || (is_res && !pwrite);

   // one wait state: the result memory answers from a register
   assign pready = s_q.ack;
   assign xfer_done = psel && penable && s_q.ack;
   assign pslverr = s_q.ack && !addr_ok;
   assign prdata = s_q.prdata;

   // ===========================================================
   // mode fields
   // ===========================================================
   assign chan_field = s_q.csr[ACS_CSR_CHAN_LSB +: ACS_CSR_CHAN_W];
   // the top channel bit is ignored: reserved codes alias onto 000..011
   assign chan_last = chan_field[ACS_CH_W-1:0]; // R17
   assign scan_mode = s_q.csr[ACS_CSR_SCAN]; // R08
   assign fast = s_q.csr[ACS_CSR_SPEED];

   // ===========================================================
   // outputs to the converter and the interrupt controller
   // ===========================================================
   assign sar_req.active = (s_q.phase == ACS_RUN);
   assign sar_req.channel = s_q.chan;
   assign conv_end_irq = s_q.csr[ACS_CSR_FLAG] && s_q.csr[ACS_CSR_IE]; // R04
   assign irq = |(s_q.irq_stat & s_q.irq_mask);

   always_comb begin
      logic flag_set;
      logic trig_fall;
      s_d = s_q;
      flag_set = 1'b0;
      trig_fall = 1'b0;
      tmr_start = 1'b0;
      tmr_len = ACS_CONV_CYC_SLOW;
      tmr_abort = 1'b0;
      mem_we = 1'b0;

      // =========================================================
      // conversion sequencer
      // =========================================================
      case (s_q.phase)
         ACS_IDLE: begin
            if (s_q.csr[ACS_CSR_START]) begin // R05
               tmr_start = 1'b1;
               tmr_len = fast ? ACS_CONV_CYC_FAST : ACS_CONV_CYC_SLOW; // R09
               // scan groups always begin at input 0
               s_d.chan = scan_mode ? '0 : chan_last; // R11 R12
               s_d.phase = ACS_RUN;
            end
         end
         ACS_RUN: begin
            if (!s_q.csr[ACS_CSR_START]) begin // R07
               tmr_abort = 1'b1;
               s_d.phase = ACS_IDLE;
            end else if (tmr_done) begin
               mem_we = 1'b1; // R14
               if (!scan_mode) begin
                  flag_set = 1'b1; // R01
                  s_d.csr[ACS_CSR_START] = 1'b0; // R06
                  s_d.phase = ACS_IDLE;
               end else begin
                  // conversions after the first of a scan use the shorter scan length, 128 or 66 states by speed
                  tmr_start = 1'b1;
                  tmr_len = fast ? ACS_SCAN_CYC_FAST : ACS_SCAN_CYC_SLOW;
                  if (s_q.chan >= chan_last) begin
                     flag_set = 1'b1; // R02
                     s_d.chan = '0; // R15
                  end else begin
                     s_d.chan = s_q.chan + 1'b1; // R07
                  end
               end
            end
         end
         default: begin
            s_d.phase = ACS_IDLE;
         end
      endcase

      // =========================================================
      // apb access
      // =========================================================
      s_d.ack = psel && penable && !s_q.ack;
      if (psel && penable && !s_q.ack) begin
         s_d.prdata = '0;
         if (!pwrite) begin
            if (is_csr) begin
               s_d.prdata[ACS_CSR_W-1:0] = s_q.csr;
            end else if (is_trig) begin
               s_d.prdata[ACS_CSR_W-1:0] = s_q.trig | ACS_TRIG_RO_ONES;
            end else if (is_res) begin
               s_d.prdata[ACS_RES_W-1:0] = mem_rdata; // R13
            end else if (is_stat) begin
               s_d.prdata[ACS_IRQ_W-1:0] = s_q.irq_stat;
            end else if (is_mask) begin
               s_d.prdata[ACS_IRQ_W-1:0] = s_q.irq_mask;
            end
         end
      end
      if (xfer_done && !pwrite && is_csr && s_q.prdata[ACS_CSR_FLAG]) begin
         s_d.flag_armed = 1'b1; // R03
      end
      if (xfer_done && pwrite) begin
         if (is_csr) begin
            // the flag cannot be set by software, only cleared after a read
            if (!pwdata[ACS_CSR_FLAG] && s_q.flag_armed) begin
               s_d.csr[ACS_CSR_FLAG] = 1'b0; // R03
            end
            s_d.flag_armed = 1'b0;
            // speed is not locked while running; software stops first
            s_d.csr[ACS_CSR_FLAG-1:0] = pwdata[ACS_CSR_FLAG-1:0]; // R05 R10
         end else if (is_trig) begin
            s_d.trig = pwdata[ACS_CSR_W-1:0] & ACS_TRIG_WR_MASK;
         end else if (is_stat) begin
            s_d.irq_stat = s_q.irq_stat & ~pwdata[ACS_IRQ_W-1:0];
         end else if (is_mask) begin
            s_d.irq_mask = pwdata[ACS_IRQ_W-1:0];
         end
      end

      // =========================================================
      // external trigger, flag and sticky events: sets win
      // =========================================================
      s_d.trig_prev = ext_conv_trigger;
      trig_fall = s_q.trig[ACS_TRIG_EN] && s_q.trig_prev && !ext_conv_trigger;
      if (trig_fall) begin
         s_d.csr[ACS_CSR_START] = 1'b1; // R16
         s_d.irq_stat[ACS_IRQ_EXT_START] = 1'b1;
      end
      if (flag_set) begin
         s_d.csr[ACS_CSR_FLAG] = 1'b1; // R01 R02
         s_d.irq_stat[ACS_IRQ_CONV_END] = 1'b1;
      end

      // =========================================================
      // standby clears the register and halts any conversion
      // =========================================================
      if (standby_req) begin
         s_d.csr = ACS_CSR_RESET; // R07
         s_d.flag_armed = 1'b0;
         s_d.phase = ACS_IDLE;
         tmr_start = 1'b0;
         tmr_abort = 1'b1;
         mem_we = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0; // R18
         s_q.csr <= ACS_CSR_RESET; // R18
         s_q.trig <= ACS_TRIG_RESET;
         s_q.phase <= ACS_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // ===========================================================
   // submodules
   // ===========================================================
   acs_conv_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .start(tmr_start),
      .len(tmr_len),
      .abort(tmr_abort),
      .done(tmr_done)
   );

   acs_result_mem u_mem (
      .pclk(pclk),
      .presetn(presetn),
      .we(mem_we),
      .waddr(s_q.chan),
      .wdata(sar_data),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

endmodule // acs_ctrl

`default_nettype wire

// ==== hdl/acs_pkg.sv ====
package acs_pkg;

   // ===========================================================
   // apb map (byte addresses, one aligned 32-bit word each)
   // ===========================================================
   localparam int ACS_ADDR_W = 8;
   localparam logic [ACS_ADDR_W-1:0] ACS_OFF_CSR = 8'h00;
   localparam logic [ACS_ADDR_W-1:0] ACS_OFF_TRIG = 8'h04;
   localparam logic [ACS_ADDR_W-1:0] ACS_OFF_RES0 = 8'h08;
   localparam logic [ACS_ADDR_W-1:0] ACS_OFF_RES3 = 8'h14;
   localparam logic [ACS_ADDR_W-1:0] ACS_OFF_IRQ_STAT = 8'h18;
   localparam logic [ACS_ADDR_W-1:0] ACS_OFF_IRQ_MASK = 8'h1C;
   localparam int ACS_WORD_LSB = 2;
   localparam logic [1:0] ACS_WORD_ALIGN = 2'h0;

   // ===========================================================
   // conversion control/status register fields
   // ===========================================================
   localparam int ACS_CSR_W = 8;
   localparam int ACS_CSR_FLAG = 7;
   localparam int ACS_CSR_IE = 6;
   localparam int ACS_CSR_START = 5;
   localparam int ACS_CSR_SCAN = 4;
   localparam int ACS_CSR_SPEED = 3;
   localparam int ACS_CSR_CHAN_LSB = 0;
   localparam int ACS_CSR_CHAN_W = 3;
   localparam logic [ACS_CSR_W-1:0] ACS_CSR_RESET = 8'h00;

   // external trigger control register: bit 7 enable, 6..4 and 1 read as one
   localparam int ACS_TRIG_EN = 7;
   localparam logic [ACS_CSR_W-1:0] ACS_TRIG_RO_ONES = 8'h72;
   localparam logic [ACS_CSR_W-1:0] ACS_TRIG_WR_MASK = 8'h8D;
   localparam logic [ACS_CSR_W-1:0] ACS_TRIG_RESET = 8'h00;

   // ===========================================================
   // interrupt status / mask layout
   // ===========================================================
   localparam int ACS_IRQ_W = 2;
   localparam int ACS_IRQ_CONV_END = 0;
   localparam int ACS_IRQ_EXT_START = 1;

   // ===========================================================
   // results
   // ===========================================================
   localparam int ACS_N_CH = 4;
   localparam int ACS_CH_W = 2;
   localparam int ACS_DATA_W = 10;
   localparam int ACS_RES_W = 16;
   localparam int ACS_RES_LSB = 6;
   localparam logic [ACS_RES_W-1:0] ACS_RES_RESET = 16'h0000;

   // ===========================================================
   // conversion timing, in states (one state is one pclk period)
   // ===========================================================
   localparam int ACS_CYC_PER_STATE = 1;
   localparam int ACS_CONV_STATES_SLOW = 134;
   localparam int ACS_CONV_STATES_FAST = 70;
   localparam int ACS_SCAN_STATES_SLOW = 128;
   localparam int ACS_SCAN_STATES_FAST = 66;
   localparam int ACS_CNT_W = 8;
   localparam logic [ACS_CNT_W-1:0] ACS_CONV_CYC_SLOW = ACS_CNT_W'(ACS_CONV_STATES_SLOW * ACS_CYC_PER_STATE);
   localparam logic [ACS_CNT_W-1:0] ACS_CONV_CYC_FAST = ACS_CNT_W'(ACS_CONV_STATES_FAST * ACS_CYC_PER_STATE);
   localparam logic [ACS_CNT_W-1:0] ACS_SCAN_CYC_SLOW = ACS_CNT_W'(ACS_SCAN_STATES_SLOW * ACS_CYC_PER_STATE);
   localparam logic [ACS_CNT_W-1:0] ACS_SCAN_CYC_FAST = ACS_CNT_W'(ACS_SCAN_STATES_FAST * ACS_CYC_PER_STATE);
   localparam logic [ACS_CNT_W-1:0] ACS_CNT_LAST = 8'h01;
   localparam logic [ACS_CNT_W-1:0] ACS_CNT_ZERO = 8'h00;

   // ===========================================================
   // types
   // ===========================================================
   typedef enum logic {ACS_IDLE, ACS_RUN} acs_phase_t;

   typedef struct packed {
      logic active;
      logic [ACS_CH_W-1:0] channel;
   } acs_sar_req_t;

   typedef struct packed {
      logic busy;
      logic [ACS_CNT_W-1:0] cnt;
   } acs_tmr_state_t;

   typedef struct packed {
      logic [ACS_N_CH-1:0][ACS_RES_W-1:0] res;
      logic [ACS_RES_W-1:0] rdata;
   } acs_mem_state_t;

   typedef struct packed {
      logic [ACS_CSR_W-1:0] csr;
      logic [ACS_CSR_W-1:0] trig;
      logic [ACS_IRQ_W-1:0] irq_stat;
      logic [ACS_IRQ_W-1:0] irq_mask;
      logic flag_armed;
      logic ack;
      logic [31:0] prdata;
      logic trig_prev;
      acs_phase_t phase;
      logic [ACS_CH_W-1:0] chan;
   } acs_ctrl_state_t;

endpackage

// ==== hdl/acs_conv_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

module acs_conv_timer
   import acs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic [ACS_CNT_W-1:0] len,
   input wire logic abort,
   output logic done
);

   acs_tmr_state_t s_q;
   acs_tmr_state_t s_d;

   // done is the last counted state; a start in that cycle reloads at once
   assign done = s_q.busy && (s_q.cnt == ACS_CNT_LAST) && !abort;

   always_comb begin
      s_d = s_q;
      if (s_q.busy) begin
         s_d.cnt = s_q.cnt - ACS_CNT_LAST;
         if (s_q.cnt == ACS_CNT_LAST) begin
            s_d.busy = 1'b0;
         end
      end
      if (start) begin
         s_d.busy = 1'b1;
         s_d.cnt = len;
      end
      if (abort) begin
         s_d.busy = 1'b0;
         s_d.cnt = ACS_CNT_ZERO;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule // acs_conv_timer

`default_nettype wire

// ==== hdl/acs_result_mem.sv ====
`timescale 1ns/1ps
`default_nettype none

module acs_result_mem
   import acs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic we,
   input wire logic [ACS_CH_W-1:0] waddr,
   input wire logic [ACS_DATA_W-1:0] wdata,
   input wire logic [ACS_CH_W-1:0] raddr,
   output logic [ACS_RES_W-1:0] rdata
);

   acs_mem_state_t s_q;
   acs_mem_state_t s_d;

   assign rdata = s_q.rdata;

   always_comb begin
      s_d = s_q;
      // ===========================================================
      // one result word per input, left-justified, low bits zero
      // ===========================================================
      for (int i = 0; i < ACS_N_CH; i++) begin
         if (we && (waddr == ACS_CH_W'(i))) begin
            s_d.res[i] = {wdata, {ACS_RES_LSB{1'b0}}}; // R13 R14
         end
      end
      s_d.rdata = s_q.res[raddr];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule // acs_result_mem

`default_nettype wire

// ==== dv/acs_ctrl_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module acs_ctrl_props
   import acs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ACS_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic ext_conv_trigger,
   input wire logic standby_req,
   input wire logic [ACS_DATA_W-1:0] sar_data,
   input wire acs_sar_req_t sar_req,
   input wire logic conv_end_irq,
   input wire logic irq
);
   // ==========================================
   // shadow of accepted csr writes; standby clears are not followed
   logic [7:0] csr_q;
   logic [8:0] run_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         csr_q <= 8'h00;
         run_q <= 9'h000;
      end else begin
         if (psel && penable && pready && pwrite && paddr == ACS_OFF_CSR && !pslverr) begin
            csr_q <= pwdata[7:0];
         end
         run_q <= sar_req.active ? run_q + 9'h001 : 9'h000;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================
   pready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no ready after wait");
   pready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
   err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
   reset_quiet_a: assert property ($rose(presetn) |-> !sar_req.active && !conv_end_irq && !irq)
      else $error("outputs active after reset");
   conv_len_a: assert property ($fell(sar_req.active) && !csr_q[4] |-> run_q == (csr_q[3] ? 9'h046 : 9'h086))
      else $error("single conversion length wrong");
   single_chan_a: assert property (sar_req.active && !csr_q[4] |-> sar_req.channel == csr_q[1:0])
      else $error("wrong single channel");
   scan_group_a: assert property (sar_req.active && csr_q[4] |-> sar_req.channel <= csr_q[1:0])
      else $error("scan left its group");
   scan_step_a: assert property (sar_req.active && $past(sar_req.active) && sar_req.channel != $past(sar_req.channel)
      |-> sar_req.channel == $past(sar_req.channel) + 2'd1 || sar_req.channel == 2'd0)
      else $error("scan order wrong");
   irq_enable_a: assert property (conv_end_irq |-> csr_q[6]) else $error("irq while disabled");
   flag_clear_a: assert property ($fell(conv_end_irq) |-> $past(pwrite && psel && penable && pready) || $past(standby_req))
      else $error("flag cleared without write");
endmodule // acs_ctrl_props
`default_nettype wire

// ==== dv/acs_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module acs_ctrl_tb
   import acs_pkg::*;
;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic pready, pslverr, conv_end_irq, irq;
   logic ext_conv_trigger = 1'b1, standby_req = 1'b0;
   logic [9:0] sar_data = 10'h000;
   acs_sar_req_t sar_req;
   logic [33:0] q[$];
   logic [33:0] e;
   logic [7:0] c;
   int errors = 0, n_checks = 0, w;
   always #2 pclk = ~pclk;
   acs_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
      .ext_conv_trigger, .standby_req, .sar_data, .sar_req, .conv_end_irq, .irq);
   // ==========================================
   task automatic chk(input string nm, input logic [32:0] ex, input logic [32:0] got);
      n_checks++;
      if (got !== ex) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // expectation bit 33 set: a write or a refused access, only the error flag is compared
   task automatic xfer(input logic wt, input logic [7:0] a, input logic [31:0] d, input logic [33:0] ex);
      int k;
      k = 0;
      q.push_back(ex);
      psel <= 1'b1;
      pwrite <= wt;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ex);
      xfer(1'b0, a, 32'h0000_0000, {2'b00, ex});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, {2'b10, 32'h0000_0000});
   endtask
   task automatic wait_irq(output int n);
      n = 0;
      while (conv_end_irq !== 1'b1 && n < 600) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 600) chk("irq wait", 33'h1, 33'h0);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         e = q.pop_front();
         if (e[33]) chk("pslverr", {32'h0000_0000, e[32]}, {32'h0000_0000, pslverr});
         else chk("prdata", e[32:0], {pslverr, prdata});
      end
   end
   initial begin
      #80000;
      errors++;
      wrap_up();
   end
   // ==========================================
   initial begin
      void'($urandom(45707));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(ACS_OFF_CSR, 32'h0000_0000);
      rd(ACS_OFF_TRIG, 32'h0000_0072);
      rd(ACS_OFF_RES0, 32'h0000_0000);
      rd(ACS_OFF_IRQ_STAT, 32'h0000_0000);
      xfer(1'b0, 8'h20, 32'h0000_0000, {2'b11, 32'h0000_0000});
      xfer(1'b1, ACS_OFF_RES0, 32'h0000_0001, {2'b11, 32'h0000_0000});
      $display("test reset done");
      wr(ACS_OFF_IRQ_MASK, 32'h0000_0001);
      for (int ch = 0; ch < 4; ch++) begin
         c = 8'h40 | {4'h0, ch[0], 1'b0, ch[1:0]};
         sar_data <= 10'($urandom);
         if (ch == 3) wr(ACS_OFF_IRQ_MASK, 32'h0000_0000);
         wr(ACS_OFF_CSR, {24'h00_0000, c | 8'h20});
         rd(ACS_OFF_CSR, {24'h00_0000, c | 8'h20});
         wait_irq(w);
         rd(ACS_OFF_RES0 + 8'(4 * ch), {16'h0000, sar_data, 6'h00});
         chk("irq", {32'h0000_0000, ch != 3}, {32'h0000_0000, irq});
         wr(ACS_OFF_CSR, {24'h00_0000, c});
         rd(ACS_OFF_CSR, {24'h00_0000, c | 8'h80});
         wr(ACS_OFF_CSR, {24'h00_0000, c});
         rd(ACS_OFF_CSR, {24'h00_0000, c});
         wr(ACS_OFF_IRQ_STAT, 32'h0000_0001);
         chk("irq", 33'h0, {32'h0000_0000, irq});
      end
      $display("test single done");
      sar_data <= 10'($urandom);
      wr(ACS_OFF_CSR, 32'h0000_007A);
      wait_irq(w);
      chk("scan wait", 33'h1, {32'h0000_0000, w > 150});
      for (int ch = 0; ch < 3; ch++) rd(ACS_OFF_RES0 + 8'(4 * ch), {16'h0000, sar_data, 6'h00});
      rd(ACS_OFF_CSR, 32'h0000_00FA);
      wr(ACS_OFF_CSR, 32'h0000_005A);
      // the sequencer sees the cleared start bit one edge after the write lands
      repeat (2) @(posedge pclk);
      chk("active", 33'h0, {32'h0000_0000, sar_req.active});
      $display("test scan done");
      wr(ACS_OFF_CSR, 32'h0000_003A);
      repeat (10) @(posedge pclk);
      standby_req <= 1'b1;
      repeat (2) @(posedge pclk);
      standby_req <= 1'b0;
      @(posedge pclk);
      chk("active", 33'h0, {32'h0000_0000, sar_req.active});
      rd(ACS_OFF_CSR, 32'h0000_0000);
      $display("test standby done");
      wr(ACS_OFF_CSR, 32'h0000_0000);
      wr(ACS_OFF_TRIG, 32'h0000_0080);
      rd(ACS_OFF_TRIG, 32'h0000_00F2);
      ext_conv_trigger <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("active", 33'h1, {32'h0000_0000, sar_req.active});
      repeat (140) @(posedge pclk);
      rd(ACS_OFF_CSR, 32'h0000_0080);
      chk("queue", 33'h0, 33'(q.size()));
      $display("test trigger done");
      wrap_up();
   end
endmodule // acs_ctrl_tb
bind acs_ctrl acs_ctrl_props props_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .prdata, .pslverr, .ext_conv_trigger, .standby_req, .sar_data, .sar_req, .conv_end_irq, .irq);
`default_nettype wire
